// ---- dnbg_pkg.sv ----
// dnbg_pkg: constants for the diagnostic interrupt and beep code block
// assumes a 125 MHz clk; no other files needed
`default_nettype none
package dnbg_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned NMI_MIN_MS     = 30;
  localparam int unsigned NMI_MIN_CYC    = NMI_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned BEEP_ON_MS     = 200;
  localparam int unsigned BEEP_GAP_MS    = 200;
  localparam int unsigned DIGIT_GAP_MS   = 800;
  localparam int unsigned BEEP_ON_CYC    = BEEP_ON_MS * 1000 * CLK_MHZ;
  localparam int unsigned BEEP_GAP_CYC   = BEEP_GAP_MS * 1000 * CLK_MHZ;
  localparam int unsigned DIGIT_GAP_CYC  = DIGIT_GAP_MS * 1000 * CLK_MHZ;
  // ----------------------------------------------------------------
  // beep codes, four digits of four bits, first digit high
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_NO_CPU    = 16'h1521;
  localparam logic [15:0] CODE_PG_DROP   = 16'h1542;
  localparam logic [15:0] CODE_PG_TMO    = 16'h1544;
  localparam logic [15:0] CODE_VR_WDT    = 16'h1512;
  localparam logic [15:0] CODE_PSU_MIX   = 16'h1514;
  localparam int unsigned NUM_FAULTS     = 5;
endpackage : dnbg_pkg
`default_nettype wire

// ---- dnbg_beeper.sv ----
// dnbg_beeper: plays one four-digit code as beep bursts
// assumes start pulses only while idle is high; same clock domain
`timescale 1ns/1ps
`default_nettype none
module dnbg_beeper #(
  parameter int unsigned ON_CYC  = dnbg_pkg::BEEP_ON_CYC,
  parameter int unsigned GAP_CYC = dnbg_pkg::BEEP_GAP_CYC,
  parameter int unsigned DIG_CYC = dnbg_pkg::DIGIT_GAP_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // request
  input  wire logic        start,
  input  wire logic [15:0] code,
  // status and speaker
  output logic             idle,
  output logic             beep
);
  typedef enum logic [1:0] {DNBG_IDLE, DNBG_ON, DNBG_GAP} dnbg_bstate_e;
  dnbg_bstate_e st, next_st;
  logic [31:0] cnt, next_cnt;
  logic [15:0] shreg, next_shreg;
  logic [3:0]  left, next_left;
  logic [2:0]  digs, next_digs;
  logic        next_beep;

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_shreg = shreg;
    next_left = left;
    next_digs = digs;
    next_beep = 1'b0;
    case (st)
      DNBG_IDLE: begin
        if (start && code[15:12] != 4'h0) begin
          next_st = DNBG_ON;
          next_cnt = ON_CYC - 1;
          next_shreg = {code[11:0], 4'h0};
          next_left = code[15:12];
          next_digs = 3'h3;
          next_beep = 1'b1;
        end
      end
      DNBG_ON: begin
        next_beep = 1'b1;
        if (cnt == 0) begin
          next_beep = 1'b0;
          next_st = DNBG_GAP;
          next_left = left - 4'h1;
          // short gap inside a digit, long pause between digits
          next_cnt = (left == 4'h1) ? DIG_CYC - 1 : GAP_CYC - 1; // RULE16
        end else begin
          next_cnt = cnt - 1;
        end
      end
      DNBG_GAP: begin
        if (cnt != 0) begin
          next_cnt = cnt - 1;
        end else if (left != 4'h0) begin
          next_st = DNBG_ON;
          next_cnt = ON_CYC - 1;
          next_beep = 1'b1;
        end else if (digs != 3'h0 && shreg[15:12] != 4'h0) begin
          // next digit: beep count equals its value
          next_left = shreg[15:12]; // RULE9
          next_shreg = {shreg[11:0], 4'h0};
          next_digs = digs - 3'h1;
          next_st = DNBG_ON;
          next_cnt = ON_CYC - 1;
          next_beep = 1'b1;
        end else begin
          next_st = DNBG_IDLE;
        end
      end
      default: next_st = DNBG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= DNBG_IDLE;
      cnt <= 32'h0;
      shreg <= 16'h0;
      left <= 4'h0;
      digs <= 3'h0;
      beep <= 1'b0;
      idle <= 1'b1;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      shreg <= next_shreg;
      left <= next_left;
      digs <= next_digs;
      beep <= next_beep;
      idle <= (next_st == DNBG_IDLE);
    end
  end
endmodule : dnbg_beeper
`default_nettype wire

// ---- dnbg_top.sv ----
// dnbg_top: diagnostic interrupt pulse and beep code generator
// assumes pins arrive asynchronous; command and watchdog strobes on clk
//
// What this block does
// RULE1 - hold each diagnostic interrupt pulse at least thirty milliseconds.
// RULE2 - after one pulse, suppress more until system reset or power-down.
// RULE3 - pulse on chassis control request, when armed.
// RULE4 - pulse on front-panel diagnostic button press, when armed.
// RULE5 - pulse on watchdog pre-timeout with interrupt action configured.
// RULE6 - chassis control cause logs no event.
// RULE7 - front-panel cause pulses and logs a sensor event.
// RULE8 - watchdog cause pulses but logs no front-panel event.
// RULE9 - each code digit sounds as that many beeps.
// RULE10 - play a code once per detection, never continuously.
// RULE11 - code 1-5-2-1 when no processor or first socket empty.
// RULE12 - code 1-5-4-2 when power good drops unexpectedly.
// RULE13 - code 1-5-4-4 when power good misses its assertion time.
// RULE14 - code 1-5-1-2 when voltage regulator watchdog sensor asserts.
// RULE15 - code 1-5-1-4 on power failure with incompatible supply fitted.
// RULE16 - short gap between beeps, longer pause between digits.
`timescale 1ns/1ps
`default_nettype none
module dnbg_top #(
  parameter int unsigned NMI_CYC = dnbg_pkg::NMI_MIN_CYC,
  parameter int unsigned ON_CYC  = dnbg_pkg::BEEP_ON_CYC,
  parameter int unsigned GAP_CYC = dnbg_pkg::BEEP_GAP_CYC,
  parameter int unsigned DIG_CYC = dnbg_pkg::DIGIT_GAP_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // interrupt causes, pulses on clk
  input  wire logic chassis_diag_req,
  input  wire logic wdt_pretimeout,
  input  wire logic wdt_action_nmi,
  // front panel button, asynchronous, active low
  input  wire logic fp_diag_btn_n,
  // system state, asynchronous levels
  input  wire logic sys_reset,
  input  wire logic sys_power_down,
  // failure detections, asynchronous levels
  input  wire logic cpu_missing,
  input  wire logic pg_dropout,
  input  wire logic pg_timeout,
  input  wire logic voltage_regulator_wdt,
  input  wire logic psu_mismatch_fail,
  // outputs
  output logic      nmi_out,
  output logic      fp_diag_event,
  output logic      beep
);
  localparam int NF = dnbg_pkg::NUM_FAULTS;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // synchroniser bit positions, faults at the bottom
  localparam int BIT_PD  = NF;
  localparam int BIT_RST = NF + 1;
  localparam int BIT_BTN = NF + 2;
  logic [BIT_BTN:0] sy1;
  logic [BIT_BTN:0] sy2;
  logic [BIT_BTN:0] sy3;
  logic [BIT_BTN:0] raw;
  // button pin is active low, inverted before the edge detector
  assign raw = {~fp_diag_btn_n,
                sys_reset,
                sys_power_down,
                psu_mismatch_fail,
                voltage_regulator_wdt,
                pg_timeout,
                pg_dropout,
                cpu_missing};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
    end else begin
      sy1 <= raw;
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  // ----------------------------------------------------------------
  // edge detection on synchronised levels
  // ----------------------------------------------------------------
  logic          btn_rise;
  logic          rearm;
  logic [NF-1:0] fault_rise;
  assign btn_rise   = sy2[BIT_BTN] & ~sy3[BIT_BTN];
  // either level re-arms; only the second stage is read
  assign rearm      = sy2[BIT_RST] | sy2[BIT_PD];
  assign fault_rise = sy2[NF-1:0] & ~sy3[NF-1:0];

  // ----------------------------------------------------------------
  // interrupt pulse
  // ----------------------------------------------------------------
  logic        armed;
  logic        next_armed;
  logic [31:0] ncnt;
  logic [31:0] next_ncnt;
  logic        next_nmi;
  logic        next_ev;
  logic        cause_any;
  // any of the three causes: sync strobes and the button edge
  assign cause_any = chassis_diag_req // RULE3
                   | btn_rise // RULE4
                   | (wdt_pretimeout & wdt_action_nmi); // RULE5
  always_comb begin
    next_armed = armed;
    next_ncnt = ncnt;
    next_nmi = nmi_out;
    next_ev = 1'b0;
    if (nmi_out) begin
      if (ncnt == 0) begin
        next_nmi = 1'b0;
      end else begin
        next_ncnt = ncnt - 1; // RULE1
      end
    end else if (armed && cause_any) begin
      next_nmi = 1'b1;
      next_ncnt = NMI_CYC - 1; // RULE1
      next_armed = 1'b0; // RULE2
    end
    // only the button logs; chassis and watchdog causes do not
    if (armed && !nmi_out && btn_rise) begin // RULE6 RULE8
      next_ev = 1'b1; // RULE7
    end
    // rearm waits for the pulse end so the pulse is never cut short
    if (rearm && !next_nmi) begin
      next_armed = 1'b1; // RULE2
    end
  end

  // ----------------------------------------------------------------
  // interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b1;
      ncnt <= 32'h0;
      nmi_out <= 1'b0;
      fp_diag_event <= 1'b0;
    end else begin
      armed <= next_armed;
      ncnt <= next_ncnt;
      nmi_out <= next_nmi;
      fp_diag_event <= next_ev;
    end
  end

  // ----------------------------------------------------------------
  // beep code selection
  // ----------------------------------------------------------------
  function automatic logic [15:0] code_of(input int unsigned idx);
    case (idx)
      0: code_of = dnbg_pkg::CODE_NO_CPU; // RULE11
      1: code_of = dnbg_pkg::CODE_PG_DROP; // RULE12
      2: code_of = dnbg_pkg::CODE_PG_TMO; // RULE13
      3: code_of = dnbg_pkg::CODE_VR_WDT; // RULE14
      default: code_of = dnbg_pkg::CODE_PSU_MIX; // RULE15
    endcase
  endfunction : code_of

  logic [NF-1:0] pend;
  logic [NF-1:0] next_pend;
  logic          b_idle;
  logic          b_start;
  logic          next_start;
  logic [15:0]   b_code;
  logic [15:0]   next_code;
  always_comb begin
    next_pend = pend | fault_rise; // RULE10
    next_start = 1'b0;
    next_code = b_code;
    if (b_idle && !b_start) begin
      for (int i = NF - 1; i >= 0; i--) begin
        if (pend[i]) begin
          next_code = code_of(i);
          next_start = 1'b1;
        end
      end
      // clear only the played one; a new rise still wins
      for (int i = 0; i < NF; i++) begin
        if (pend[i] && next_code == code_of(i) && !fault_rise[i]) begin
          next_pend[i] = 1'b0; // RULE10
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // code launch registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend <= '0;
      b_start <= 1'b0;
      b_code <= 16'h0;
    end else begin
      pend <= next_pend;
      b_start <= next_start;
      b_code <= next_code;
    end
  end

  // ----------------------------------------------------------------
  // burst player
  // ----------------------------------------------------------------
  dnbg_beeper #(
    .ON_CYC  (ON_CYC),
    .GAP_CYC (GAP_CYC),
    .DIG_CYC (DIG_CYC)
  ) u_beeper (
    .clk   (clk),
    .nrst  (nrst),
    .start (b_start),
    .code  (b_code),
    .idle  (b_idle),
    .beep  (beep)
  );
endmodule : dnbg_top
`default_nettype wire

// ---- dnbg_checker.sv ----
// dnbg_checker: port assertions for dnbg_top
// assumes bind into dnbg_top, one clock
`timescale 1ns/1ps
`default_nettype none
module dnbg_checker #(
  parameter int unsigned NMI_CYC = dnbg_pkg::NMI_MIN_CYC,
  parameter int unsigned ON_CYC  = dnbg_pkg::BEEP_ON_CYC,
  parameter int unsigned GAP_CYC = dnbg_pkg::BEEP_GAP_CYC,
  parameter int unsigned DIG_CYC = dnbg_pkg::DIGIT_GAP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // causes and rearm levels
  input wire logic chassis_diag_req,
  input wire logic wdt_pretimeout,
  input wire logic wdt_action_nmi,
  input wire logic sys_reset,
  input wire logic sys_power_down,
  // outputs
  input wire logic nmi_out,
  input wire logic fp_diag_event,
  input wire logic beep
);
  // ----
  // helpers
  // ----
  logic        nmi_q;
  logic        fired;
  logic [1:0]  rearm_d;
  logic [31:0] ncnt;
  logic [31:0] bcnt;
  logic [31:0] lcnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nmi_q <= 1'h0;
      fired <= 1'h0;
      rearm_d <= 2'h0;
      ncnt  <= 32'h0;
      bcnt  <= 32'h0;
      lcnt  <= GAP_CYC;
    end else begin
      nmi_q <= nmi_out;
      // two stages, as the design sees its rearm levels
      rearm_d <= {rearm_d[0], sys_reset | sys_power_down};
      if (nmi_out && !nmi_q) fired <= 1'h1;
      else if (rearm_d[1] && (!nmi_out || ncnt == NMI_CYC - 1)) fired <= 1'h0;
      ncnt <= nmi_out ? ncnt + 32'h1 : 32'h0;
      bcnt <= beep ? bcnt + 32'h1 : 32'h0;
      lcnt <= beep ? 32'h0 : lcnt + 32'h1;
    end
  end
  // ----
  // assertions
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_nmi_width: assert property ($fell(nmi_out) |-> ncnt == NMI_CYC)
    else $error("interrupt pulse width wrong");
  a_nmi_rearm: assert property (nmi_out && !nmi_q |-> !fired)
    else $error("interrupt pulsed before rearm");
  a_nmi_cause: assert property ($rose(nmi_out) |-> $past(chassis_diag_req)
    || ($past(wdt_pretimeout) && $past(wdt_action_nmi)) || fp_diag_event)
    else $error("interrupt without cause");
  a_chassis_fire: assert property (chassis_diag_req && !nmi_out && !fired |=> nmi_out)
    else $error("chassis request ignored");
  a_wdt_fire: assert property (wdt_pretimeout && wdt_action_nmi && !nmi_out && !fired
    |=> nmi_out) else $error("watchdog cause ignored");
  a_fp_event: assert property (fp_diag_event |-> $rose(nmi_out) ##1 !fp_diag_event)
    else $error("button event not with pulse");
  a_chassis_nolog: assert property (chassis_diag_req |=> !fp_diag_event)
    else $error("chassis cause logged");
  a_wdt_nolog: assert property (wdt_pretimeout |=> !fp_diag_event)
    else $error("watchdog cause logged");
  a_beep_len: assert property ($fell(beep) |-> bcnt == ON_CYC)
    else $error("beep length wrong");
  a_beep_gap: assert property ($rose(beep) |-> lcnt == GAP_CYC || lcnt >= DIG_CYC)
    else $error("beep gap wrong");
  c_nmi: cover property ($rose(nmi_out));
  c_fp: cover property (fp_diag_event);
  c_beep: cover property ($rose(beep));
endmodule : dnbg_checker
bind dnbg_top dnbg_checker #(.NMI_CYC(NMI_CYC), .ON_CYC(ON_CYC), .GAP_CYC(GAP_CYC),
  .DIG_CYC(DIG_CYC)) chk_u (.clk, .nrst, .chassis_diag_req, .wdt_pretimeout,
  .wdt_action_nmi, .sys_reset, .sys_power_down, .nmi_out, .fp_diag_event, .beep);
`default_nettype wire

// ---- dnbg_listener.sv ----
// dnbg_listener: speaker model, turns beep bursts into digit counts
// assumes silence longer than the beep gap ends a digit
`timescale 1ns/1ps
`default_nettype none
module dnbg_listener #(
  parameter int unsigned SIL_CYC = 6
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // speaker and digits heard
  input  wire logic       beep,
  output var  logic [7:0] digit,
  output var  logic       digit_v
);
  logic        beep_q;
  logic [7:0]  cnt;
  logic [31:0] quiet;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beep_q  <= 1'h0;
      cnt     <= 8'h0;
      quiet   <= 32'h0;
      digit   <= 8'h0;
      digit_v <= 1'h0;
    end else begin
      beep_q  <= beep;
      quiet   <= beep ? 32'h0 : quiet + 32'h1;
      digit_v <= 1'h0;
      if (beep && !beep_q) cnt <= cnt + 8'h1;
      if (!beep && quiet == SIL_CYC && cnt != 8'h0) begin
        digit_v <= 1'h1;
        digit   <= cnt;
        cnt     <= 8'h0;
      end
    end
  end
endmodule : dnbg_listener
`default_nettype wire

// ---- test_diag_nmi_beep_generator.sv ----
// test_diag_nmi_beep_generator: interrupt causes, rearm and beep codes
// assumes dnbg_top, dnbg_listener and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_diag_nmi_beep_generator;
  localparam int unsigned NMI_CYC = 20;
  logic clk = 0, nrst = 0, chassis_diag_req = 0, wdt_pretimeout = 0, wdt_action_nmi = 0;
  logic fp_diag_btn_n = 1, sys_reset = 0, sys_power_down = 0, nmi_out, fp_diag_event, beep;
  logic [4:0]  flt = 5'h0;
  logic [7:0]  digit, q[$];
  logic        digit_v, nmi_q = 0;
  int          errors = 0, checks_done = 0, tick = 0, j;
  logic [15:0] codes[5] = '{dnbg_pkg::CODE_NO_CPU, dnbg_pkg::CODE_PG_DROP,
    dnbg_pkg::CODE_PG_TMO, dnbg_pkg::CODE_VR_WDT, dnbg_pkg::CODE_PSU_MIX};
  always #4 clk = ~clk;
  dnbg_top #(.NMI_CYC(NMI_CYC), .ON_CYC(3), .GAP_CYC(3), .DIG_CYC(10)) dut_u (.clk, .nrst,
    .chassis_diag_req, .wdt_pretimeout, .wdt_action_nmi, .fp_diag_btn_n, .sys_reset,
    .sys_power_down, .cpu_missing(flt[0]), .pg_dropout(flt[1]), .pg_timeout(flt[2]),
    .voltage_regulator_wdt(flt[3]), .psu_mismatch_fail(flt[4]), .nmi_out, .fp_diag_event,
    .beep);
  dnbg_listener spk_u (.clk, .nrst, .beep, .digit, .digit_v);
  // ----
  // tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic cause(input int k);
    @(negedge clk);
    if (k == 0) chassis_diag_req = 1;
    else if (k == 1) wdt_pretimeout = 1;
    else fp_diag_btn_n = 0;
    @(negedge clk);
    chassis_diag_req = 0;
    wdt_pretimeout = 0;
    repeat (NMI_CYC + 10) @(negedge clk);
    fp_diag_btn_n = 1;
  endtask : cause
  // ----
  // monitor and timeout
  // ----
  always @(negedge clk) begin
    if (nmi_out && !nmi_q) check({7'h50, fp_diag_event}, q.size() ? q.pop_front() : 8'hEE);
    if (digit_v) check(digit, q.size() ? q.pop_front() : 8'hEE);
    nmi_q = nmi_out;
  end
  always @(posedge clk) if (++tick == 6000) begin
    errors++;
    results();
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    void'($urandom(32'h391B));
    wdt_action_nmi = 1;
    for (int k = 0; k < 3; k++) begin
      q.push_back({7'h50, k == 2});
      cause(k);
      cause(k);
      sys_reset = !k[0];
      sys_power_down = k[0];
      repeat (6) @(negedge clk);
      {sys_reset, sys_power_down} = 2'h0;
      repeat (4) @(negedge clk);
      $display("test cause %0d done", k);
    end
    wdt_action_nmi = 0;
    cause(1);
    $display("test watchdog disabled done");
    for (int i = 0; i < 6; i++) begin
      j = i < 5 ? i : $urandom % 5;
      for (int d = 3; d >= 0; d--) q.push_back({4'h0, codes[j][d*4 +: 4]});
      repeat ($urandom % 7) @(negedge clk);
      flt[j] = 1;
      repeat (260) @(negedge clk);
      flt[j] = 0;
      repeat (5) @(negedge clk);
      $display("test code %0d done", j);
    end
    check(q.size(), 0);
    results();
  end
endmodule : test_diag_nmi_beep_generator
`default_nettype wire
